// ===== verilog/glue_regs.svh
// Purpose: Constants for the processor glue logic
// Assumes: 100 MHz core clock
// Notes: Definitions only
`ifndef GLUE_REGS_SVH
`define GLUE_REGS_SVH

// Program memory window
`define PROG_BASE 16'h0000
`define PROG_LAST 16'h7FFF
// Working RAM window
`define RAM_BASE 16'hA000
`define RAM_LAST 16'hBFFF

// Core clock rate
`define CORE_CLK_MHZ 100
// Power-up hold time, stands in for the RC charge delay
`define POR_DELAY_US 100
`define POR_CYCLES (`POR_DELAY_US * `CORE_CLK_MHZ)

// Reset value of the power-up counter
`define POR_CNT_RESET 32'h0000_0000

`endif

// ===== verilog/glue_pkg.sv
// Purpose: Types for the processor glue logic
// Assumes: Constants come from glue_regs.svh
// Notes: State of each module is one packed struct
package glue_pkg;

  typedef enum logic [0:0] {
    POR_HOLD = 1'b0,
    POR_RUN  = 1'b1
  } por_state_e;

  typedef logic [31:0] count_t;

  // Pin bits: power_good, host_link_tx, iso_rx, spare_tx, spare_rx
  typedef struct packed {
    logic [4:0] pin_m;
    logic [4:0] pin_s;
    logic [2:0] xtal;
    logic cpu_clk;
    logic adc_clk;
    por_state_e por;
    count_t por_cnt;
    logic rst_hi;
    logic rst_lo_n;
    logic iso_tx;
    logic link_rx;
    logic spare_tx;
    logic spare_rx;
  } glue_state_s;

  typedef struct packed {
    logic [15:0] addr_m;
    logic [15:0] addr_s;
    logic strobe_n_m;
    logic strobe_n_s;
    logic prog_sel_n;
    logic ram_sel_n;
  } dec_state_s;

endpackage

// ===== verilog/glue_bus_if.sv
// Purpose: Memory cycle signals between kernel top and decoder
// Assumes: Address and strobe come raw from processor pins
// Notes: Selects are active low
`timescale 1ns/10ps
interface glue_bus_if;
  logic [15:0] addr;
  logic mem_enable_strobe_n;
  logic prog_sel_n;
  logic ram_sel_n;

  modport decoder (
    input addr,
    input mem_enable_strobe_n,
    output prog_sel_n,
    output ram_sel_n
  );

  modport kernel (
    output addr,
    output mem_enable_strobe_n,
    input prog_sel_n,
    input ram_sel_n
  );
endinterface

// ===== verilog/mem_decoder.sv
// Purpose: Program memory and working RAM select decode
// Assumes: Address and strobe are asynchronous to the core clock
// Notes: Two-flop sync adds latency; selects are registered
`timescale 1ns/10ps
`include "glue_regs.svh"
module mem_decoder (
  input wire logic clk,
  input wire logic rst,
  glue_bus_if.decoder bus
);

  glue_pkg::dec_state_s q;
  glue_pkg::dec_state_s d;

  always_comb begin
    d = q;
    d.addr_m = bus.addr;
    d.addr_s = q.addr_m;
    d.strobe_n_m = bus.mem_enable_strobe_n;
    d.strobe_n_s = q.strobe_n_m;
    // Both selects idle unless strobe active and address in a window
    d.prog_sel_n = 1'b1;
    d.ram_sel_n = 1'b1;
    if (!q.strobe_n_s) begin
      if (q.addr_s >= `PROG_BASE && q.addr_s <= `PROG_LAST) begin
        d.prog_sel_n = 1'b0;
      end
      if (q.addr_s >= `RAM_BASE && q.addr_s <= `RAM_LAST) begin
        d.ram_sel_n = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{addr_m: 16'h0000, addr_s: 16'h0000, strobe_n_m: 1'b1,
             strobe_n_s: 1'b1, prog_sel_n: 1'b1, ram_sel_n: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign bus.prog_sel_n = q.prog_sel_n;
  assign bus.ram_sel_n = q.ram_sel_n;

endmodule

// ===== verilog/kernel_glue.sv
// Purpose: Glue logic around the sensing board processor
// Assumes: Crystal, processor pins and supply monitor are asynchronous
// Notes: All pin inputs except RESET pass a two-flop synchroniser first
`timescale 1ns/10ps
`include "glue_regs.svh"

// Summary of operation
// - Program memory select is active only for strobed cycles at 0000h-7FFFh.
// - Working RAM select is active only for strobed cycles at A000h-BFFFh.
// - The processor clock output runs at half the 6.144 MHz crystal rate.
// - A toggle stage halves the processor clock to make the converter clock.
// - At power-up both resets stay asserted until the charge delay elapses.
// - On supply loss both resets are asserted at once.
// - The outgoing host transmit line is inverted before the isolator.
// - Host link traffic runs both ways through isolators.
// - The spare serial channel is only buffered and carries no protocol.
// - The host link uses 4800 baud, 8 data bits, odd parity, one stop bit.
module kernel_glue #(
  parameter int unsigned POR_CYCLES = `POR_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic XTAL_CLK,
  input wire logic POWER_GOOD,
  input wire logic [15:0] ADDR,
  input wire logic MEMORY_ENABLE_STROBE_N,
  input wire logic HOST_LINK_TX,
  input wire logic ISO_RX,
  input wire logic SPARE_LINK_TX,
  input wire logic SPARE_LINK_RX,
  output logic PROG_SEL_N,
  output logic RAM_SEL_N,
  output logic CPU_CLOCK_OUT,
  output logic ADC_CLK,
  output logic SYS_RESET,
  output logic SYS_RESET_N,
  output logic ISO_TX_DRIVE,
  output logic HOST_LINK_RX,
  output logic SPARE_TX_BUF,
  output logic SPARE_RX_BUF
);

  if (POR_CYCLES < 1) begin : g_bad_por
    $error("POR_CYCLES must be at least 1");
  end

  localparam glue_pkg::count_t POR_LAST =
    glue_pkg::count_t'(POR_CYCLES - 1);

  glue_pkg::glue_state_s q;
  glue_pkg::glue_state_s d;
  glue_bus_if bus ();

  logic pg_s;
  logic xtal_rise;

  assign pg_s = q.pin_s[4];
  assign xtal_rise = q.xtal[1] & ~q.xtal[2];

  always_comb begin
    d = q;
    d.pin_m = {POWER_GOOD, HOST_LINK_TX, ISO_RX, SPARE_LINK_TX,
               SPARE_LINK_RX};
    d.pin_s = q.pin_m;
    d.xtal = {q.xtal[1], q.xtal[0], XTAL_CLK};
    // Power-up hold, then run; supply loss returns to hold at once
    case (q.por)
      glue_pkg::POR_HOLD: begin
        d.rst_hi = 1'b1;
        d.rst_lo_n = 1'b0;
        if (!pg_s) begin
          d.por_cnt = `POR_CNT_RESET;
        end else if (q.por_cnt == POR_LAST) begin
          d.por = glue_pkg::POR_RUN;
          d.rst_hi = 1'b0;
          d.rst_lo_n = 1'b1;
        end else begin
          d.por_cnt = q.por_cnt + 32'h0000_0001;
        end
      end
      glue_pkg::POR_RUN: begin
        if (!pg_s) begin
          d.por = glue_pkg::POR_HOLD;
          d.por_cnt = `POR_CNT_RESET;
          d.rst_hi = 1'b1;
          d.rst_lo_n = 1'b0;
        end
      end
      default: begin
        d.por = glue_pkg::POR_HOLD;
      end
    endcase
    // Clock chain held at a known phase while reset is active
    if (q.rst_hi) begin
      d.cpu_clk = 1'b0;
      d.adc_clk = 1'b0;
    end else if (xtal_rise) begin
      d.cpu_clk = ~q.cpu_clk;
      if (q.cpu_clk) begin
        d.adc_clk = ~q.adc_clk;
      end
    end
    // Host transmit line is inverted, other link lines pass untouched; framing is the processors' business
    d.iso_tx = ~q.pin_s[3];
    d.link_rx = q.pin_s[2];
    d.spare_tx = q.pin_s[1];
    d.spare_rx = q.pin_s[0];
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      // Link pins start at their idle high level, so no false edge
      q <= '{pin_m: 5'h0F, pin_s: 5'h0F, xtal: 3'h0, cpu_clk: 1'b0,
             adc_clk: 1'b0, por: glue_pkg::POR_HOLD,
             por_cnt: `POR_CNT_RESET, rst_hi: 1'b1, rst_lo_n: 1'b0,
             iso_tx: 1'b0, link_rx: 1'b1, spare_tx: 1'b1,
             spare_rx: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign bus.addr = ADDR;
  assign bus.mem_enable_strobe_n = MEMORY_ENABLE_STROBE_N;

  mem_decoder u_dec (
    .clk(CORE_CLK),
    .rst(RESET),
    .bus(bus.decoder)
  );

  assign PROG_SEL_N = bus.prog_sel_n;
  assign RAM_SEL_N = bus.ram_sel_n;
  assign CPU_CLOCK_OUT = q.cpu_clk;
  assign ADC_CLK = q.adc_clk;
  assign SYS_RESET = q.rst_hi;
  assign SYS_RESET_N = q.rst_lo_n;
  assign ISO_TX_DRIVE = q.iso_tx;
  assign HOST_LINK_RX = q.link_rx;
  assign SPARE_TX_BUF = q.spare_tx;
  assign SPARE_RX_BUF = q.spare_rx;

endmodule

// ===== test/kernel_glue_properties.sv
// Purpose: Port-level checks of the glue logic
// Assumes: Three-edge path through sync and register
// Notes: Bound to kernel_glue below
`timescale 1ns/10ps
module kernel_glue_properties (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic POWER_GOOD,
  input wire logic [15:0] ADDR,
  input wire logic MEMORY_ENABLE_STROBE_N,
  input wire logic HOST_LINK_TX,
  input wire logic ISO_RX,
  input logic PROG_SEL_N,
  input logic RAM_SEL_N,
  input logic CPU_CLOCK_OUT,
  input logic ADC_CLK,
  input logic SYS_RESET,
  input logic SYS_RESET_N,
  input logic ISO_TX_DRIVE,
  input logic HOST_LINK_RX
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  a_prog_sel_on: assert property (
    (!ADDR[15] && !MEMORY_ENABLE_STROBE_N)[*3] |=> !PROG_SEL_N)
    else $error("prog select missing");
  a_ram_sel_on: assert property (
    (ADDR[15:13] == 3'b101 && !MEMORY_ENABLE_STROBE_N)[*3] |=> !RAM_SEL_N)
    else $error("ram select missing");
  a_no_stray_sel: assert property (
    !RAM_SEL_N |-> $past(ADDR[15:13], 3) == 3'b101
      && !$past(MEMORY_ENABLE_STROBE_N, 3)) else $error("stray ram select");
  a_no_stray_prog: assert property (
    !PROG_SEL_N |-> !$past(ADDR[15], 3)
      && !$past(MEMORY_ENABLE_STROBE_N, 3)) else $error("stray prog select");
  a_adc_halves: assert property (
    $rose(ADC_CLK) |-> $fell(CPU_CLOCK_OUT)) else $error("adc clock phase");
  a_div_cleared: assert property (
    SYS_RESET && $past(SYS_RESET) |-> !ADC_CLK && !CPU_CLOCK_OUT)
    else $error("divider not cleared");
  a_supply_loss: assert property (
    !POWER_GOOD |-> ##3 SYS_RESET && !SYS_RESET_N) else $error("no reset");
  a_tx_invert: assert property (
    $fell(HOST_LINK_TX) ##1 !HOST_LINK_TX[*2] |=> ISO_TX_DRIVE)
    else $error("tx not inverted");
  a_rx_pass: assert property (
    $rose(ISO_RX) ##1 ISO_RX[*2] |=> HOST_LINK_RX) else $error("rx lost");
  cover property (!PROG_SEL_N);
  cover property (!RAM_SEL_N);
  cover property ($rose(ADC_CLK));
endmodule

bind kernel_glue kernel_glue_properties props (.*);

// ===== test/link_partner.sv
// Purpose: Controller board end of the isolated host link
// Assumes: Bit time shortened to BIT_CYC core cycles
// Notes: Start, 8 data lsb first, odd parity, stop
`timescale 1ns/10ps
module link_partner #(
  parameter int BIT_CYC = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic iso_tx,
  output logic iso_rx,
  output logic [8:0] got,
  output logic got_ok
);
  initial iso_rx = 1'b1;
  task automatic send(input logic [7:0] d);
    logic [10:0] f;
    f = {1'b1, ~^d, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(negedge clk);
      iso_rx = f[i];
      repeat (BIT_CYC - 1) @(negedge clk);
    end
  endtask
  // Line idles low here, the isolator undoes the inversion
  always begin
    got_ok = 1'b0;
    @(posedge clk iff (iso_tx && !rst));
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      got[i] = ~iso_tx;
    end
    repeat (BIT_CYC) @(posedge clk);
    got_ok = ~iso_tx;
    @(posedge clk);
  end
endmodule

// ===== test/mcu_kernel_glue_logic_tb_top.sv
// Purpose: Self-checking bench for the glue logic
// Assumes: Short power-up count and bit time
// Notes: Serial results scored from a queue
`timescale 1ns/10ps
module mcu_kernel_glue_logic_tb_top;
  localparam int POR = 16;
  localparam int BIT = 8;
  logic clk = 0, rst = 1, xtal = 0, pg = 1, strobe_n = 1, tx = 1;
  logic stx = 1, srx = 1, prog_n, ram_n, cpu, adc, sr, sr_n, itx, hrx;
  logic stb, srb, iso_rx, got_ok;
  logic [15:0] addr = 16'h0000;
  logic [8:0] got;
  logic [8:0] q[$];
  logic [2:0] rx_h = 3'b111;
  logic [15:0] tab[8] = '{16'h0000, 16'h7FFF, 16'h8000, 16'h9FFF,
    16'hA000, 16'hBFFF, 16'hC000, 16'hFFFF};
  int err_count = 0, checked = 0, seed = 84, cpu_r = 0, adc_r = 0, n;
  kernel_glue #(.POR_CYCLES(POR)) dut (
    .CORE_CLK(clk), .RESET(rst), .XTAL_CLK(xtal), .POWER_GOOD(pg),
    .ADDR(addr), .MEMORY_ENABLE_STROBE_N(strobe_n), .HOST_LINK_TX(tx),
    .ISO_RX(iso_rx), .SPARE_LINK_TX(stx), .SPARE_LINK_RX(srx),
    .PROG_SEL_N(prog_n), .RAM_SEL_N(ram_n), .CPU_CLOCK_OUT(cpu),
    .ADC_CLK(adc), .SYS_RESET(sr), .SYS_RESET_N(sr_n),
    .ISO_TX_DRIVE(itx), .HOST_LINK_RX(hrx), .SPARE_TX_BUF(stb),
    .SPARE_RX_BUF(srb));
  link_partner #(.BIT_CYC(BIT)) lp (.clk(clk), .rst(sr), .iso_tx(itx),
    .iso_rx(iso_rx), .got(got), .got_ok(got_ok));
  always #5 clk = ~clk;
  always #81.38 xtal = ~xtal;
  always @(posedge cpu) cpu_r++;
  always @(posedge adc) adc_r++;
  always @(negedge clk) if (got_ok) chk("host_link", got, q.pop_front());
  // Receive line shows up three core edges after the isolator
  always @(posedge clk) rx_h = {rx_h[1:0], iso_rx};
  always @(negedge clk) if (sr === 1'b0) chk("host_rx", hrx, rx_h[2]);
  task automatic chk(input string nm, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up;
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Bounded wait for the power-up hold to end
  task automatic wait_low;
    n = 0;
    while (sr !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) begin
      err_count++;
      wrap_up();
    end
    chk("por_len", n >= POR, 1'b1);
  endtask
  task automatic dec(input logic [15:0] a, input logic s);
    logic ep, er;
    ep = !s && !a[15];
    er = !s && a[15:13] == 3'b101;
    @(negedge clk);
    addr = a;
    strobe_n = s;
    stx = 1'($random(seed));
    srx = 1'($random(seed));
    repeat (4) @(negedge clk);
    chk("prog_sel_n", prog_n, !ep);
    chk("ram_sel_n", ram_n, !er);
    chk("spare", {stb, srb}, {stx, srx});
  endtask
  task automatic send_tx(input logic [7:0] d);
    logic [10:0] f;
    f = {1'b1, ~^d, d, 1'b0};
    q.push_back({~^d, d});
    for (int i = 0; i < 11; i++) begin
      @(negedge clk);
      tx = f[i];
      repeat (BIT - 1) @(negedge clk);
    end
  endtask
  initial begin
    logic [7:0] b;
    repeat (4) @(negedge clk);
    rst = 0;
    wait_low();
    foreach (tab[i]) for (int s = 0; s < 2; s++) dec(tab[i], s[0]);
    repeat (20) dec(16'($random(seed)), 1'($random(seed)));
    @(posedge xtal);
    cpu_r = 0;
    adc_r = 0;
    repeat (16) @(posedge xtal);
    chk("cpu_rises", 16'(cpu_r), 16'h0008);
    chk("adc_rises", 16'(adc_r), 16'h0004);
    repeat (4) begin
      b = 8'($random(seed));
      fork
        lp.send(~b);
        send_tx(b);
      join
    end
    @(negedge clk);
    pg = 0;
    repeat (3) @(negedge clk);
    chk("sys_reset", {sr, sr_n}, 2'b10);
    pg = 1;
    wait_low();
    repeat (20) @(negedge clk);
    chk("pending", 16'(q.size()), 16'h0000);
    wrap_up();
  end
endmodule
